// >>> hw/pic_clk_div.sv
// Divider that makes the internal PHY clock from the core clock
`timescale 1ns/1ps
`default_nettype none
module pic_clk_div
    import pic_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    output logic o_clk
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic clk_q;
    logic clk_d;

    always_comb
    begin
        cnt_d = cnt_q + 4'h1;
        clk_d = clk_q;
        if (cnt_q == 4'(PIC_DIV_HALF - 1))
        begin
            cnt_d = 4'h0;
            clk_d = ~clk_q;
        end
        if (i_reset)
        begin
            cnt_d = 4'h0;
            clk_d = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        cnt_q <= cnt_d;
        clk_q <= clk_d;
    end

    assign o_clk = clk_q;
endmodule // pic_clk_div
`default_nettype wire

// >>> hw/pic_sync.sv
// Two flip-flop synchroniser for a level
`timescale 1ns/1ps
`default_nettype none
module pic_sync
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_async,
    output logic o_sync
);
    logic meta_q;
    logic sync_q;
    logic meta_d;
    logic sync_d;

    always_comb
    begin
        meta_d = i_async;
        sync_d = meta_q;
        if (i_reset)
        begin
            meta_d = 1'b0;
            sync_d = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign o_sync = sync_q;
endmodule // pic_sync
`default_nettype wire

// >>> hw/pic_top.sv
// PHY interface control register bank with APB slave
`timescale 1ns/1ps
`default_nettype none
module pic_top
    import pic_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic i_standby,
    input wire logic i_phy_external_clock_in,
    output logic o_phy_clk,
    output logic o_phy_soft_reset_n,
    output logic [2:0] o_phy_start_mode,
    output logic o_phy_clk_sel,
    output logic o_phy_autoneg_en,
    output logic o_phy_adv_all,
    output logic o_phy_speed100,
    output logic o_phy_full_duplex,
    output logic o_phy_power_down,
    output logic o_phy_crs_on_tx,
    output logic o_phy_onchip_en
);
    // ------------------------------------------------------------
    // Input synchronisers and internal clock
    // ------------------------------------------------------------
    logic stby_s;
    logic ext_clk_s;
    logic int_clk;

    pic_sync u_sync_stby
    (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_async(i_standby),
        .o_sync(stby_s)
    );

    pic_sync u_sync_extclk
    (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_async(i_phy_external_clock_in),
        .o_sync(ext_clk_s)
    );

    pic_clk_div u_div
    (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .o_clk(int_clk)
    );

    // ------------------------------------------------------------
    // APB slave and registers
    // ------------------------------------------------------------
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic onchip_q;
    logic onchip_d;
    logic ready_q;
    logic ready_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic err_q;
    logic err_d;
    logic acc;
    logic wr;
    logic [15:0] ctrl_view;
    logic [15:0] wmask;

    always_comb
    begin
        acc = i_psel && i_penable && !ready_q;
        wr = acc && i_pwrite;
        ctrl_view = (ctrl_q & PIC_CTRL_WMASK) | PIC_CTRL_FIXED;
        wmask = PIC_CTRL_WMASK & {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
        ctrl_d = ctrl_q;
        onchip_d = onchip_q;
        ready_d = acc;
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        if (acc)
        begin
            case (i_paddr)
                PIC_OFF_CTRL:
                begin
                    rdata_d = {16'h0000, ctrl_view};
                    if (wr)
                    begin
                        ctrl_d = (ctrl_q & ~wmask) | (i_pwdata[15:0] & wmask);
                    end
                end
                PIC_OFF_STAT:
                begin
                    rdata_d = {24'h00_0000, stby_s, o_phy_soft_reset_n,
                               o_phy_clk_sel, o_phy_onchip_en, 1'b0, o_phy_start_mode};
                end
                PIC_OFF_PSEL:
                begin
                    rdata_d = {31'h0000_0000, onchip_q};
                    if (wr && i_pstrb[0])
                    begin
                        onchip_d = i_pwdata[0];
                    end
                end
                default:
                begin
                    err_d = 1'b1;
                end
            endcase
        end
        if (stby_s)
        begin
            ctrl_d = PIC_CTRL_STBY_VAL;
        end
        if (i_reset)
        begin
            ctrl_d = PIC_CTRL_RST_VAL;
            onchip_d = PIC_PSEL_RST_VAL;
            ready_d = 1'b0;
            rdata_d = 32'h0000_0000;
            err_d = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        ctrl_q <= ctrl_d;
        onchip_q <= onchip_d;
        ready_q <= ready_d;
        rdata_q <= rdata_d;
        err_q <= err_d;
    end

    // ------------------------------------------------------------
    // PHY side: latched settings and decoded mode
    // ------------------------------------------------------------
    logic rstn_q;
    logic rstn_d;
    logic [2:0] mode_q;
    logic [2:0] mode_d;
    logic cksel_q;
    logic cksel_d;
    logic pclk_q;
    logic pclk_d;
    logic an_q;
    logic an_d;
    logic adv_q;
    logic adv_d;
    logic s100_q;
    logic s100_d;
    logic fd_q;
    logic fd_d;
    logic pd_q;
    logic pd_d;
    logic crs_q;
    logic crs_d;
    logic onp_q;
    logic onp_d;

    always_comb
    begin
        rstn_d = ctrl_q[PIC_BIT_RSTN];
        mode_d = mode_q;
        cksel_d = cksel_q;
        if (!ctrl_q[PIC_BIT_RSTN])
        begin
            mode_d = ctrl_q[PIC_MODE_HI:0];
            cksel_d = ctrl_q[PIC_BIT_CKSEL];
        end
        if (i_reset)
        begin
            rstn_d = PIC_CTRL_RST_VAL[PIC_BIT_RSTN];
            mode_d = PIC_CTRL_RST_VAL[PIC_MODE_HI:0];
            cksel_d = PIC_CTRL_RST_VAL[PIC_BIT_CKSEL];
        end
        pclk_d = cksel_d ? ext_clk_s : int_clk;
        an_d = 1'b0;
        adv_d = 1'b0;
        s100_d = 1'b0;
        fd_d = 1'b0;
        pd_d = 1'b0;
        case (pic_mode_t'(mode_d))
            PIC_M10_HALF, PIC_M10_FULL, PIC_M100_HALF, PIC_M100_FULL:
            begin
                s100_d = mode_d[1];
                fd_d = mode_d[0];
            end
            PIC_MAN_100H:
            begin
                an_d = 1'b1;
                s100_d = 1'b1;
            end
            PIC_MAN_ALL:
            begin
                an_d = 1'b1;
                adv_d = 1'b1;
                s100_d = 1'b1;
                fd_d = 1'b1;
            end
            PIC_MPDOWN:
            begin
                pd_d = 1'b1;
            end
            default:
            begin
                pd_d = 1'b0;
            end
        endcase
        crs_d = s100_d && !fd_d && !pd_d;
        onp_d = i_reset ? PIC_PSEL_RST_VAL : onchip_q;
        if (i_reset)
        begin
            pclk_d = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        rstn_q <= rstn_d;
        mode_q <= mode_d;
        cksel_q <= cksel_d;
        pclk_q <= pclk_d;
        an_q <= an_d;
        adv_q <= adv_d;
        s100_q <= s100_d;
        fd_q <= fd_d;
        pd_q <= pd_d;
        crs_q <= crs_d;
        onp_q <= onp_d;
    end

    assign o_pready = ready_q;
    assign o_prdata = rdata_q;
    assign o_pslverr = err_q;
    assign o_phy_clk = pclk_q;
    assign o_phy_soft_reset_n = rstn_q;
    assign o_phy_start_mode = mode_q;
    assign o_phy_clk_sel = cksel_q;
    assign o_phy_autoneg_en = an_q;
    assign o_phy_adv_all = adv_q;
    assign o_phy_speed100 = s100_q;
    assign o_phy_full_duplex = fd_q;
    assign o_phy_power_down = pd_q;
    assign o_phy_crs_on_tx = crs_q;
    assign o_phy_onchip_en = onp_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    sequence s_ctrl_wr_rst_low;
        i_psel && i_penable && !ready_q && i_pwrite && i_paddr == PIC_OFF_CTRL
            && i_pstrb[1] && !i_pwdata[PIC_BIT_RSTN] && !stby_s;
    endsequence

    sequence s_ctrl_read;
        o_pready && !o_pslverr && $past(i_pwrite) == 1'b0
            && $past(i_paddr) == PIC_OFF_CTRL;
    endsequence

    a_reset_bit_drive: assert property (s_ctrl_wr_rst_low |-> ##2 !o_phy_soft_reset_n)
        else $error("soft reset did not follow control write");
    a_fixed_bit_read: assert property (s_ctrl_read |-> o_prdata[PIC_BIT_FIXED])
        else $error("bit 15 did not read as one");
    a_reserved_read_zero: assert property (s_ctrl_read
        |-> o_prdata[PIC_RSV_HI:PIC_RSV_LO] == 10'h000)
        else $error("reserved bits read nonzero");
    a_mode_held_run: assert property (o_phy_soft_reset_n && $past(o_phy_soft_reset_n, 2)
        |-> $stable(o_phy_start_mode) && $stable(o_phy_clk_sel))
        else $error("mode changed outside module reset");
    a_fixed_mode_decode: assert property (!o_phy_start_mode[2] |-> !o_phy_autoneg_en
        && o_phy_speed100 == o_phy_start_mode[1]
        && o_phy_full_duplex == o_phy_start_mode[0])
        else $error("fixed mode decoded wrongly");
    a_autoneg_decode: assert property (o_phy_start_mode == 3'h4
        |-> o_phy_autoneg_en && !o_phy_adv_all && !o_phy_full_duplex)
        else $error("auto-negotiation mode decoded wrongly");
    a_power_down_decode: assert property (o_phy_power_down == (o_phy_start_mode == 3'h6))
        else $error("power down not tied to its code");
    a_carrier_tx: assert property ((o_phy_start_mode == 3'h2 || o_phy_start_mode == 3'h4)
        == o_phy_crs_on_tx)
        else $error("carrier on transmit wrong for mode");
    a_standby_force: assert property (stby_s |=> ctrl_q == PIC_CTRL_STBY_VAL)
        else $error("standby did not force control value");
    a_clk_internal_rate: assert property ($rose(o_phy_clk) && !cksel_d
        && !$past(o_phy_clk_sel) ##1 !o_phy_clk_sel[*3]
        |-> ##1 ($rose(o_phy_clk) || o_phy_clk_sel))
        else $error("internal PHY clock period wrong");
    a_ready_one_cycle: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
endmodule // pic_top
`default_nettype wire

// >>> shared/pic_pkg.sv
// Constants for the PHY interface control block
package pic_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] PIC_OFF_CTRL = 12'h000;
    localparam logic [11:0] PIC_OFF_STAT = 12'h004;
    localparam logic [11:0] PIC_OFF_PSEL = 12'h008;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int PIC_CTRL_W = 16;
    localparam int PIC_BIT_FIXED = 15;
    localparam int PIC_BIT_RSTN = 14;
    localparam int PIC_BIT_CKSEL = 13;
    localparam int PIC_RSV_HI = 12;
    localparam int PIC_RSV_LO = 3;
    localparam int PIC_MODE_HI = 2;
    localparam logic [15:0] PIC_CTRL_RST_VAL = 16'hC006;
    localparam logic [15:0] PIC_CTRL_STBY_VAL = 16'hC000;
    localparam logic [15:0] PIC_CTRL_WMASK = 16'h6007;
    localparam logic [15:0] PIC_CTRL_FIXED = 16'h8000;
    localparam logic PIC_PSEL_RST_VAL = 1'b1;
    // ------------------------------------------------------------
    // Start modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PIC_M10_HALF = 3'h0,
        PIC_M10_FULL = 3'h1,
        PIC_M100_HALF = 3'h2,
        PIC_M100_FULL = 3'h3,
        PIC_MAN_100H = 3'h4,
        PIC_MRESERVED = 3'h5,
        PIC_MPDOWN = 3'h6,
        PIC_MAN_ALL = 3'h7
    } pic_mode_t;
    // ------------------------------------------------------------
    // Clock figures
    // ------------------------------------------------------------
    localparam int PIC_CORE_CLK_MHZ = 100;
    localparam int PIC_PHY_CLK_MHZ = 25;
    localparam int PIC_DIV_HALF = PIC_CORE_CLK_MHZ / (2 * PIC_PHY_CLK_MHZ);
    localparam int PIC_PHY_PERIOD_CYC = 2 * PIC_DIV_HALF;
endpackage

// >>> testbench/phy_interface_control_tb_top.sv
// Self-checking testbench for the PHY interface control block
`timescale 1ns/1ps
`default_nettype none
module phy_interface_control_tb_top
    import pic_pkg::*;
;
    logic clk, rst, psel, pen, pwr, stby, rdy, err, rn, cs, an, aa, s100, fd, pd, crs, onc;
    logic pclk, ext;
    logic [11:0] addr;
    logic [31:0] wd, rd, d;
    logic [3:0] strb;
    logic [2:0] mode, cap, mv;
    logic [33:0] expq [$];
    logic [5:0] exp_tab [0:7] = '{6'h00, 6'h04, 6'h09, 6'h0C, 6'h29, 6'h00, 6'h02, 6'h30};
    logic [5:0] msk_tab [0:7] = '{6'h3E, 6'h3E, 6'h3F, 6'h3F, 6'h33, 6'h00, 6'h12, 6'h32};
    int errors, num_checks, seed, n, m, rises, c0;
    wire logic [10:0] phy_o = {rn, mode, cs, an, aa, s100, fd, pd, crs};
    // ------------------------------------------------------------
    // Design and partner
    // ------------------------------------------------------------
    pic_top i_dut (.i_core_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .i_pstrb(strb), .o_pready(rdy),
        .o_prdata(rd), .o_pslverr(err), .i_standby(stby), .i_phy_external_clock_in(ext),
        .o_phy_clk(pclk), .o_phy_soft_reset_n(rn), .o_phy_start_mode(mode),
        .o_phy_clk_sel(cs), .o_phy_autoneg_en(an), .o_phy_adv_all(aa),
        .o_phy_speed100(s100), .o_phy_full_duplex(fd), .o_phy_power_down(pd),
        .o_phy_crs_on_tx(crs), .o_phy_onchip_en(onc));
    pic_phy_model i_phy (.i_reset_n(rn), .i_mode(mode), .o_ext_clk(ext), .o_cap_mode(cap));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task final_report;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task fail(input string s);
        errors++;
        $display("unexpected at %0t: %s", $time, s);
    endtask
    task cmp_bus(input logic [33:0] e);
        num_checks++;
        if (err !== e[32] || (e[33] && rd !== e[31:0]))
            fail("bus answer");
    endtask
    task cmp_phy(input logic [10:0] g, input logic [10:0] e, input logic [10:0] k);
        num_checks++;
        if (((g ^ e) & k) !== 11'h000)
            fail("phy outputs");
    endtask
    task cmp_val(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
            fail("value");
    endtask
    task wait_n(input int k);
        repeat (k) @(posedge clk);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] dd, input logic [33:0] e);
        expq.push_back(e);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wd <= dd;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (rdy === 1'b1)
                break;
        end
        if (n == 20)
        begin
            fail("no ready");
            final_report;
        end
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // Clock, watchers
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge pclk) rises++;
    always @(posedge clk)
        if (rdy === 1'b1)
        begin
            if (expq.size() == 0)
                fail("stray ready");
            else
                cmp_bus(expq.pop_front());
        end
    initial
    begin
        #1000000;
        fail("timeout");
        final_report;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 51;
        errors = 0;
        num_checks = 0;
        rises = 0;
        rst = 1'b1;
        {psel, pen, pwr, stby} = 4'h0;
        addr = 12'h000;
        wd = 32'h0;
        strb = 4'hF;
        wait_n(12);
        rst <= 1'b0;
        apb(1'b0, PIC_OFF_CTRL, 32'h0, {2'h2, 32'h0000C006});
        cmp_phy(phy_o, {5'h1C, exp_tab[6]}, {5'h1F, msk_tab[6]});
        cmp_val({7'h0, onc}, 8'h01);
        c0 = rises;
        wait_n(80);
        cmp_val(8'(rises - c0), 8'h14);
        $display("test reset done");
        repeat (3)
        begin
            d = $random(seed);
            d[15:14] = 2'h3;
            d[12:3] = 10'h000;
            if (d[2:0] == 3'h5)
                d[0] = 1'b0;
            apb(1'b1, PIC_OFF_CTRL, d, 34'h0);
            apb(1'b0, PIC_OFF_CTRL, 32'h0, {2'h2, 16'h0, 2'h3, d[13], 10'h0, d[2:0]});
        end
        cmp_phy(phy_o, 11'h700, 11'h7C0);
        $display("test fields done");
        for (m = 0; m < 8; m++)
            if (m != 5)
            begin
                mv = m[2:0];
                apb(1'b1, PIC_OFF_CTRL, {16'h0, 2'h2, mv[0], 10'h0, mv}, 34'h0);
                wait_n(10001);
                cmp_phy(phy_o, {1'b0, mv, mv[0], exp_tab[m]}, {5'h1F, msk_tab[m]});
                apb(1'b1, PIC_OFF_CTRL, {16'h0, 2'h3, mv[0], 10'h0, mv}, 34'h0);
                wait_n(4);
                cmp_val({5'h0, cap}, {5'h0, mv});
                cmp_phy(phy_o, {1'b1, mv, mv[0], 6'h0}, 11'h7C0);
            end
        c0 = rises;
        wait_n(80);
        cmp_val({7'h0, (rises - c0) inside {[19:21]}}, 8'h01);
        apb(1'b1, PIC_OFF_CTRL, 32'h0000E002, 34'h0);
        wait_n(4);
        cmp_phy(phy_o, 11'h7FC, 11'h7FF);
        $display("test modes done");
        apb(1'b0, 12'h00C, 32'h0, {2'h3, 32'h0});
        apb(1'b1, PIC_OFF_PSEL, 32'h0, 34'h0);
        wait_n(3);
        cmp_val({7'h0, onc}, 8'h00);
        apb(1'b1, PIC_OFF_PSEL, 32'h1, 34'h0);
        stby <= 1'b1;
        wait_n(5);
        apb(1'b1, PIC_OFF_CTRL, 32'h0000C003, 34'h0);
        apb(1'b0, PIC_OFF_CTRL, 32'h0, {2'h2, 32'h0000C000});
        apb(1'b0, PIC_OFF_STAT, 32'h0, {2'h2, 32'h000000F7});
        stby <= 1'b0;
        wait_n(3);
        cmp_phy(phy_o, 11'h7FC, 11'h7FF);
        apb(1'b0, PIC_OFF_STAT, 32'h0, {2'h2, 32'h00000077});
        $display("test standby done");
        wait_n(3);
        if (expq.size() != 0)
            fail("answers missing");
        final_report;
    end
endmodule // phy_interface_control_tb_top
`default_nettype wire

// >>> testbench/pic_phy_model.sv
// Behavioural on-chip PHY seen from the control block
`timescale 1ns/1ps
`default_nettype none
module pic_phy_model
(
    input wire logic i_reset_n,
    input wire logic [2:0] i_mode,
    output logic o_ext_clk,
    output logic [2:0] o_cap_mode
);
    // ------------------------------------------------------------
    // Free running 25 MHz oscillator on the external clock pin
    // ------------------------------------------------------------
    initial
    begin
        o_ext_clk = 1'b0;
        forever #20 o_ext_clk = ~o_ext_clk;
    end
    // ------------------------------------------------------------
    // Mode taken in when the module reset is released
    // ------------------------------------------------------------
    // No management frame is ever sent, so the settle time after release holds
    always @(posedge i_reset_n)
        o_cap_mode <= i_mode;
endmodule // pic_phy_model
`default_nettype wire
